//--- shared/tsu_pkg.sv
// Function
// - Capture reference tick count into 16-bit result
// - Count reference ticks across electrode charge cycles
// - Charge-discharge repetitions configurable up to 4096
// - Up to 16 channels; selected pin is connected
// - Interrupt only when enabled and DMA unselected
// - Scan starts by software or hardware trigger
// - Low power triggers accepted; wake on event
// - In stop modes run only with stop enable
// - Trigger scans channel from data register field
// - Run/wait: interrupt every completion when enabled; code does so only with bit 28 set and DMA off
// - End-of-scan flag holds until software acknowledges
// - Bit 31 flags result outside threshold window
// - Out-of-range only in capacitive sensing mode
// - Write one clears out-of-range flag; zero ignored
// - Control bits 30 and 29 read zero
// - Bit 28 selects interrupt source event
// - Registers at consecutive words from 4004_5000, reset zero
// - Mode field 27:24; upper bits nonzero mean noise
package tsu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] TSU_GCS_ADDR  = 32'h4004_5000;
  localparam logic [31:0] TSU_DATA_ADDR = 32'h4004_5004;
  localparam logic [31:0] TSU_THR_ADDR  = 32'h4004_5008;
  localparam logic [31:0] TSU_CNT_ADDR  = 32'h4004_500C;
  localparam logic [31:0] TSU_REG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TSU_OUTRG_BIT   = 31;
  localparam int TSU_SRC_BIT     = 28;
  localparam int TSU_MODE_LSB    = 24;
  localparam int TSU_ANALOG_LSB  = 16;
  localparam int TSU_EOS_BIT     = 15;
  localparam int TSU_MODEN_BIT   = 7;
  localparam int TSU_IRQEN_BIT   = 6;
  localparam int TSU_STOPEN_BIT  = 5;
  localparam int TSU_TRIGM_BIT   = 4;
  localparam int TSU_BUSY_BIT    = 3;
  localparam int TSU_CH_LSB      = 28;
  localparam int TSU_DMAEN_BIT   = 23;
  localparam int TSU_SWTRIG_BIT  = 22;
  localparam int TSU_THR_HI_LSB  = 16;
  localparam int TSU_MAX_CH      = 16;
  localparam int TSU_REP_W       = 12;
  localparam logic [1:0]  TSU_MODE_CAP_HI  = 2'h0;
  localparam logic [15:0] TSU_TICK_MAX     = 16'hFFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       module_enable;
    logic       interrupt_enable;
    logic       stop_enable;
    logic       trigger_mode;
    logic       irq_src_sel;
    logic       dma_enable;
    logic [3:0] mode;
    logic [7:0] analog;
    logic [3:0] channel_select;
  } tsu_cfg_s;

  typedef enum logic {TSU_IDLE, TSU_SCAN} tsu_state_e;

endpackage

//--- verilog/tsu_scan_ctrl.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module tsu_scan_ctrl
  import tsu_pkg::*;
#(
  parameter int NUM_CH = TSU_MAX_CH
)(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Register port
  input  wire logic [31:0]       addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  // Measurement front end
  input  wire logic              ref_tick,
  input  wire logic [NUM_CH-1:0] electrode_osc,
  input  wire logic              hw_trigger,
  input  wire logic              stop_mode,
  output logic      [NUM_CH-1:0] electrode_en,
  output logic                   scan_busy,
  // Events to the system
  output logic                   irq,
  output logic                   dma_req,
  output logic                   wakeup
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > TSU_MAX_CH) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tsu_state_e           state_r;
  tsu_state_e           state_nxt;
  tsu_cfg_s             cfg_r;
  tsu_cfg_s             cfg_nxt;
  logic [31:0]          thr_r;
  logic [TSU_REP_W-1:0] cnt_r;
  logic [TSU_REP_W-1:0] rep_cnt_r;
  logic [15:0]          tick_cnt_r;
  logic [15:0]          result_r;
  logic                 eos_flag_r;
  logic                 outrg_r;
  logic                 osc_prev_r;
  logic [31:0]          rdata_r;
  logic                 irq_r;
  logic                 dma_req_r;
  logic                 wakeup_r;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Registers sit on consecutive words from the base
  wire sel_gcs  = (addr == TSU_GCS_ADDR);
  wire sel_data = (addr == TSU_DATA_ADDR);
  wire sel_thr  = (addr == TSU_THR_ADDR);
  wire sel_cnt  = (addr == TSU_CNT_ADDR);
  wire wr_gcs   = wr & sel_gcs;
  wire wr_data  = wr & sel_data;
  wire wr_thr   = wr & sel_thr;
  wire wr_cnt   = wr & sel_cnt;

  // ----------------------------------------------------------------
  // Trigger and scan qualification
  // ----------------------------------------------------------------
  // Stop modes block starts and abort a running scan unless stop enable is set
  wire allowed  = cfg_r.module_enable & (~stop_mode | cfg_r.stop_enable);
  wire sw_trig  = wr_data & wdata[TSU_SWTRIG_BIT];
  // Trigger source picked by the trigger mode bit
  wire trig_sel = cfg_r.trigger_mode ? hw_trigger : sw_trig;
  wire is_idle  = (state_r == TSU_IDLE);
  wire is_scan  = (state_r == TSU_SCAN);
  wire start    = is_idle & allowed & trig_sel;
  wire abort    = is_scan & ~allowed;

  // Selected electrode, zero-extended so an unbuilt channel never toggles
  wire [TSU_MAX_CH-1:0] osc_ext = TSU_MAX_CH'(electrode_osc);
  wire osc_sel  = osc_ext[cfg_r.channel_select];
  wire osc_edge = osc_sel & ~osc_prev_r;
  // A trigger may retarget the channel; prime the detector with the new pad
  wire osc_next_ch = osc_ext[cfg_nxt.channel_select];
  wire osc_prime   = start ? osc_next_ch : osc_sel;

  // Last repetition ends the scan; >= guards a count lowered mid-scan
  wire last_rep = osc_edge & (rep_cnt_r >= cnt_r);
  wire done     = is_scan & allowed & last_rep;

  // Reference ticks accumulate, saturating at 16 bits
  wire [15:0] tick_nxt = (ref_tick && tick_cnt_r != TSU_TICK_MAX) ?
                         tick_cnt_r + 16'h0001 : tick_cnt_r;

  // ----------------------------------------------------------------
  // Range check and flag events
  // ----------------------------------------------------------------
  wire [15:0] thr_lo   = thr_r[15:0];
  wire [15:0] thr_hi   = thr_r[TSU_THR_HI_LSB +: 16];
  // Window compare on the value just captured
  wire        oor      = (tick_nxt < thr_lo) | (tick_nxt > thr_hi);
  // Noise modes have nonzero upper mode bits and never flag
  wire        cap_mode = (cfg_r.mode[3:2] == TSU_MODE_CAP_HI);
  wire        outrg_set = done & oor & cap_mode;
  wire        eos_set   = done;
  wire        eos_clr   = wr_gcs & wdata[TSU_EOS_BIT];
  // Write one clears; a zero leaves the flag alone
  wire        outrg_clr = wr_gcs & wdata[TSU_OUTRG_BIT];
  // Interrupt source: out-of-range when clear, end-of-scan when set
  wire        src_flag  = cfg_r.irq_src_sel ? eos_flag_r : outrg_r;
  wire        src_event = cfg_r.irq_src_sel ? eos_set : outrg_set;

  // ----------------------------------------------------------------
  // Configuration next value
  // ----------------------------------------------------------------
  // Enables are sampled live; changing them mid-scan is software's fault
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_gcs) begin
      cfg_nxt.module_enable    = wdata[TSU_MODEN_BIT];
      cfg_nxt.interrupt_enable = wdata[TSU_IRQEN_BIT];
      cfg_nxt.stop_enable      = wdata[TSU_STOPEN_BIT];
      cfg_nxt.trigger_mode     = wdata[TSU_TRIGM_BIT];
      cfg_nxt.irq_src_sel      = wdata[TSU_SRC_BIT];
      cfg_nxt.mode             = wdata[TSU_MODE_LSB +: 4];
      cfg_nxt.analog           = wdata[TSU_ANALOG_LSB +: 8];
    end
    if (wr_data) begin
      cfg_nxt.channel_select   = wdata[TSU_CH_LSB +: 4];
      cfg_nxt.dma_enable       = wdata[TSU_DMAEN_BIT];
    end
  end

  // Scan sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TSU_IDLE: begin
        if (start) begin
          state_nxt = TSU_SCAN;
        end
      end
      TSU_SCAN: begin
        if (done || abort) begin
          state_nxt = TSU_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= TSU_IDLE;
      cfg_r   <= tsu_cfg_s'(0);
      thr_r   <= TSU_REG_RESET;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cfg_r   <= cfg_nxt;
      thr_r   <= wr_thr ? wdata : thr_r;
      cnt_r   <= wr_cnt ? wdata[TSU_REP_W-1:0] : cnt_r;
    end
  end

  // Counters restart on every scan start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rep_cnt_r  <= '0;
      tick_cnt_r <= '0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_prime;
      if (start) begin
        rep_cnt_r  <= '0;
        tick_cnt_r <= '0;
      end else if (is_scan) begin
        tick_cnt_r <= tick_nxt;
        rep_cnt_r  <= osc_edge ? rep_cnt_r + 1'b1 : rep_cnt_r;
      end
    end
  end

  // Result capture and sticky flags; a set beats a same-cycle clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_r   <= '0;
      eos_flag_r <= 1'b0;
      outrg_r    <= 1'b0;
    end else begin
      result_r   <= done ? tick_nxt : result_r;
      eos_flag_r <= eos_set | (eos_flag_r & ~eos_clr);
      outrg_r    <= outrg_set | (outrg_r & ~outrg_clr);
    end
  end

  // Event outputs: level interrupt, pulsed DMA and wake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_r     <= 1'b0;
      dma_req_r <= 1'b0;
      wakeup_r  <= 1'b0;
    end else begin
      irq_r     <= cfg_r.interrupt_enable & ~cfg_r.dma_enable & src_flag;
      dma_req_r <= done & cfg_r.dma_enable;
      wakeup_r  <= stop_mode & cfg_r.interrupt_enable & src_event;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Bits 30:29 are wired to zero, writes there are dropped
  wire [31:0] gcs_rd  = {outrg_r, 2'b00, cfg_r.irq_src_sel, cfg_r.mode, cfg_r.analog,
                         eos_flag_r, 7'h00, cfg_r.module_enable, cfg_r.interrupt_enable,
                         cfg_r.stop_enable, cfg_r.trigger_mode, is_scan, 3'h0};
  wire [31:0] data_rd = {cfg_r.channel_select, 4'h0, cfg_r.dma_enable, 7'h00, result_r};
  wire [31:0] cnt_rd  = {{(32-TSU_REP_W){1'b0}}, cnt_r};
  // Unmapped reads return zero
  wire [31:0] rd_mux  = sel_gcs  ? gcs_rd  :
                        sel_data ? data_rd :
                        sel_thr  ? thr_r   :
                        sel_cnt  ? cnt_rd  : 32'h0000_0000;

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only the selected pad is switched to the analog path
  for (genvar i = 0; i < NUM_CH; i++) begin : g_pad
    assign electrode_en[i] = is_scan & (cfg_r.channel_select == 4'(i));
  end

  assign rdata     = rdata_r;
  assign scan_busy = is_scan;
  assign irq       = irq_r;
  assign dma_req   = dma_req_r;
  assign wakeup    = wakeup_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_trigger;
    is_idle && allowed && trig_sel;
  endsequence

  sequence s_scan_on;
    is_scan && scan_busy;
  endsequence

  a_result_capture: assert property (done |=> result_r == $past(tick_nxt))
    else $error("result not captured at end of scan");

  a_tick_count: assert property (is_scan && ref_tick && !done && !abort &&
                                 tick_cnt_r < TSU_TICK_MAX
                                 |=> tick_cnt_r == $past(tick_cnt_r) + 16'h0001)
    else $error("reference tick not counted");

  a_scan_length: assert property (is_scan && allowed && !last_rep |=> is_scan)
    else $error("scan ended before the set repetitions");

  a_pad_select: assert property ($onehot0(electrode_en) &&
                                 (!is_idle || electrode_en == '0))
    else $error("wrong electrode connected");

  a_irq_gate: assert property (irq |-> $past(cfg_r.interrupt_enable) &&
                               !$past(cfg_r.dma_enable))
    else $error("interrupt without enable or with DMA");

  a_trig_start: assert property (s_trigger |=> s_scan_on ##0 electrode_en != '0 ||
                                 NUM_CH <= cfg_r.channel_select)
    else $error("trigger did not start a scan");

  a_stop_idle: assert property (stop_mode && !cfg_r.stop_enable && is_idle
                                |=> is_idle)
    else $error("scan started in stop without stop enable");

  a_wake_event: assert property (done && stop_mode && cfg_r.interrupt_enable &&
                                 cfg_r.irq_src_sel |=> wakeup)
    else $error("no wake on end of scan in stop");

  a_eos_hold: assert property (eos_flag_r && !eos_clr |=> eos_flag_r [*1])
    else $error("end-of-scan flag dropped without acknowledge");

  a_range_mode: assert property ($rose(outrg_r) |-> $past(cap_mode) && $past(done))
    else $error("out-of-range set outside sensing mode");

  a_range_clear: assert property (outrg_r && outrg_clr && !outrg_set |=> !outrg_r)
    else $error("write one did not clear out-of-range");

  a_resv_zero: assert property (rd && sel_gcs |=> rdata[30:29] == 2'b00)
    else $error("reserved bits read nonzero");

  a_irq_source: assert property (irq |->
                                 $past(cfg_r.irq_src_sel ? eos_flag_r : outrg_r))
    else $error("interrupt from unselected source");

  // Scan completion ends the scan and raises the sticky flag
  sequence s_done;
    is_scan && allowed && last_rep;
  endsequence

  a_scan_finish: assert property (s_done |=> is_idle && eos_flag_r)
    else $error("scan end did not set end-of-scan flag");

  // Counters start from zero on every trigger
  a_count_clear: assert property (start |=> tick_cnt_r == 16'h0000 && rep_cnt_r == '0)
    else $error("scan counters not cleared at start");

  // Each pad edge during a scan is one repetition
  a_rep_step: assert property (is_scan && osc_edge |=>
                               rep_cnt_r == $past(rep_cnt_r) + 1'b1)
    else $error("repetition not counted");

  // Only the selected channel's pad is connected while scanning
  a_chan_pick: assert property (is_scan |->
                                electrode_en == NUM_CH'(16'h0001 << cfg_r.channel_select))
    else $error("scan on a channel other than the selected one");

  // Each trigger mode ignores the other source
  a_hw_only: assert property (is_idle && cfg_r.trigger_mode && !hw_trigger |=> is_idle)
    else $error("scan started without hardware trigger");

  a_sw_only: assert property (is_idle && !cfg_r.trigger_mode && !sw_trig |=> is_idle)
    else $error("scan started without software trigger");

  // Leaving the allowed state mid-scan drops the scan and keeps the old result
  a_abort_idle: assert property (abort |=> is_idle && result_r == $past(result_r))
    else $error("aborted scan kept running or changed the result");

  // Interrupt follows the selected flag while enabled without DMA
  a_irq_level: assert property (cfg_r.interrupt_enable && !cfg_r.dma_enable && src_flag
                                |=> irq)
    else $error("enabled interrupt not raised");

  // DMA request pulses only after a DMA-enabled scan end
  a_dma_pulse: assert property (dma_req |-> $past(done) && $past(cfg_r.dma_enable))
    else $error("DMA request without a DMA scan end");

  // Wake only in stop with the interrupt enabled
  a_wake_gate: assert property (wakeup |->
                                $past(stop_mode) && $past(cfg_r.interrupt_enable))
    else $error("wake outside stop or without enable");

  // Window compare sets the flag in sensing mode
  a_range_set: assert property (done && cap_mode &&
                                (tick_nxt < thr_lo || tick_nxt > thr_hi) |=> outrg_r)
    else $error("result outside window not flagged");

  // Noise modes never raise the out-of-range flag
  a_mode_noise: assert property (done && cfg_r.mode[3:2] != TSU_MODE_CAP_HI && !outrg_r
                                 |=> !outrg_r)
    else $error("out-of-range raised in a noise mode");

  // Read data stands for one cycle and is zero otherwise
  a_read_idle: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data outside the read cycle");

  a_read_result: assert property (rd && sel_data |=> rdata[15:0] == $past(result_r))
    else $error("result not returned by a read");

endmodule

//--- verif/tsu_electrode_model.sv
`timescale 1ns/1ps
module tsu_electrode_model
  import tsu_pkg::*;
#(
  parameter int NUM_CH   = TSU_MAX_CH,
  parameter int TICK_DIV = 3
)(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Pads and pacing
  input  wire logic [NUM_CH-1:0] electrode_en,
  input  wire logic [3:0]        half_per,
  output logic                   ref_tick,
  output logic [NUM_CH-1:0]      electrode_osc
);
  // ----------------------------------------------------------------
  // Reference ticks and pad oscillation
  // ----------------------------------------------------------------
  logic [7:0] tk_r;
  logic [3:0] ph_r;

  // Loose pads toggle every cycle so a wrong channel pick shows up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tk_r          <= 8'h00;
      ph_r          <= 4'h0;
      ref_tick      <= 1'b0;
      electrode_osc <= '0;
    end else begin
      tk_r     <= (int'(tk_r) == TICK_DIV - 1) ? 8'h00 : tk_r + 8'h01;
      ref_tick <= (tk_r == 8'h00);
      ph_r     <= (electrode_en == '0 || ph_r >= half_per) ? 4'h0 : ph_r + 4'h1;
      for (int i = 0; i < NUM_CH; i++) begin
        if (!electrode_en[i] || ph_r >= half_per) begin
          electrode_osc[i] <= ~electrode_osc[i];
        end
      end
    end
  end
endmodule

//--- verif/capacitive_touch_scan_control_tb.sv
`timescale 1ns/1ps
module capacitive_touch_scan_control_tb;
  import tsu_pkg::*;
  logic        clock, rst, wr, rd, hw_trigger, stop_mode, ref_tick;
  logic        scan_busy, irq, dma_req, wakeup, irq_seen;
  logic [31:0] addr, wdata, rdata, rv;
  logic [15:0] electrode_osc, electrode_en, osc_q;
  logic [3:0]  half_per, cur_ch;
  int          num_errors, n_tests, ticks, edges, en_bad, dma_cnt, wake_cnt;

  // ----------------------------------------------------------------
  // Design, far side and clock
  // ----------------------------------------------------------------
  tsu_scan_ctrl tsu_scan_ctrl_inst (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ref_tick(ref_tick), .electrode_osc(electrode_osc),
    .hw_trigger(hw_trigger), .stop_mode(stop_mode), .electrode_en(electrode_en),
    .scan_busy(scan_busy), .irq(irq), .dma_req(dma_req), .wakeup(wakeup));
  tsu_electrode_model tsu_electrode_model_inst (.clock(clock), .rst(rst),
    .electrode_en(electrode_en), .half_per(half_per), .ref_tick(ref_tick),
    .electrode_osc(electrode_osc));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Counts what the scan sees, same edge detection as the design
  always @(posedge clock) begin
    osc_q <= electrode_osc;
    if (scan_busy === 1'b1) begin
      ticks += int'(ref_tick === 1'b1);
      edges += int'(|(electrode_osc & ~osc_q & electrode_en));
      en_bad += int'(electrode_en !== (16'h0001 << cur_ch));
    end
    dma_cnt += int'(dma_req === 1'b1);
    wake_cnt += int'(wakeup === 1'b1);
  end

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  // One spare edge after each strobe keeps strobes from being reassigned in one step
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Config is written only while idle, never mid-scan
  task automatic scan(input logic [3:0] c, input logic hw, input logic dma,
                      input logic [11:0] cnt, input logic [31:0] gcs);
    int i;
    reg_wr(TSU_GCS_ADDR, gcs | 32'h8000_8000);
    reg_wr(TSU_CNT_ADDR, {20'h00000, cnt});
    cur_ch = c;
    ticks = 0;
    edges = 0;
    en_bad = 0;
    if (hw) begin
      reg_wr(TSU_DATA_ADDR, {c, 28'h0000000});
      hw_trigger <= 1'b1;
      @(posedge clock);
      hw_trigger <= 1'b0;
      @(posedge clock);
    end else begin
      reg_wr(TSU_DATA_ADDR, {c, 4'h0, dma, 1'b1, 22'h000000});
    end
    chk("busy", 32'h1, {31'h0, scan_busy});
    for (i = 0; i < 10000 && scan_busy === 1'b1; i++) @(negedge clock);
    @(posedge clock);
    @(negedge clock);
    irq_seen = irq;
    @(posedge clock);
    chk("edges", 32'(cnt) + 32'h1, 32'(edges));
    chk("pad_select", 32'h0, 32'(en_bad));
    reg_rd(TSU_DATA_ADDR, rv);
    chk("result", 32'(ticks), {16'h0000, rv[15:0]});
    chk("channel", {28'h0, c}, {28'h0, rv[31:28]});
    reg_rd(TSU_GCS_ADDR, rv);
    chk("eos_flag", 32'h1, {31'h0, rv[15]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    reg_rd(TSU_GCS_ADDR, rv);
    chk("gcs_reset", TSU_REG_RESET, rv);
    reg_rd(TSU_DATA_ADDR, rv);
    chk("data_reset", TSU_REG_RESET, rv);
    reg_rd(TSU_THR_ADDR, rv);
    chk("thr_reset", TSU_REG_RESET, rv);
    reg_rd(32'h4004_5010, rv);
    chk("unmapped", 32'h0, rv);
    reg_wr(TSU_GCS_ADDR, 32'h7FFF_7FFF);
    reg_rd(TSU_GCS_ADDR, rv);
    chk("gcs_rw", 32'h1FFF_00F0, rv);
    reg_wr(TSU_GCS_ADDR, 32'h0);
    reg_wr(TSU_DATA_ADDR, 32'hF000_FFFF);
    reg_rd(TSU_DATA_ADDR, rv);
    chk("data_ro", 32'hF000_0000, rv);
    reg_wr(TSU_THR_ADDR, 32'hA5A5_5A5A);
    reg_rd(TSU_THR_ADDR, rv);
    chk("thr_rw", 32'hA5A5_5A5A, rv);
    $display("test_regs done");
  endtask

  task automatic test_eos_irq();
    reg_wr(TSU_THR_ADDR, 32'hFFFF_0000);
    half_per <= 4'h5;
    scan(4'h5, 1'b0, 1'b0, 12'h003, 32'h1000_00C0);
    chk("irq_eos", 32'h1, {31'h0, irq_seen});
    reg_rd(TSU_GCS_ADDR, rv);
    chk("eos_hold", 32'h1, {31'h0, rv[15]});
    reg_wr(TSU_GCS_ADDR, 32'h1000_80C0);
    reg_rd(TSU_GCS_ADDR, rv);
    chk("eos_clear", 32'h1000_00C0, rv);
    chk("irq_drop", 32'h0, {31'h0, irq});
    dma_cnt = 0;
    half_per <= 4'h0;
    scan(4'h0, 1'b0, 1'b1, 12'h000, 32'h1000_00C0);
    chk("dma_req", 32'h1, 32'(dma_cnt));
    chk("irq_dma", 32'h0, {31'h0, irq_seen});
    $display("test_eos_irq done");
  endtask

  task automatic test_range();
    reg_wr(TSU_THR_ADDR, 32'hFFFF_FFFF);
    scan(4'hF, 1'b0, 1'b0, 12'h002, 32'h0000_00C0);
    chk("irq_oor", 32'h1, {31'h0, irq_seen});
    chk("oor_set", 32'h1, {31'h0, rv[31]});
    reg_wr(TSU_GCS_ADDR, 32'h0000_00C0);
    reg_rd(TSU_GCS_ADDR, rv);
    chk("oor_keep", 32'h1, {31'h0, rv[31]});
    reg_wr(TSU_GCS_ADDR, 32'h8000_00C0);
    reg_rd(TSU_GCS_ADDR, rv);
    chk("oor_w1c", 32'h0, {31'h0, rv[31]});
    scan(4'h1, 1'b0, 1'b0, 12'h002, 32'h0400_00C0);
    chk("oor_noise", 32'h0, {31'h0, rv[31]});
    chk("irq_noise", 32'h0, {31'h0, irq_seen});
    $display("test_range done");
  endtask

  task automatic test_stop_hw();
    reg_wr(TSU_GCS_ADDR, 32'h1000_80D0);
    reg_wr(TSU_CNT_ADDR, 32'h0000_0FFF);
    reg_wr(TSU_DATA_ADDR, 32'h3000_0000);
    hw_trigger <= 1'b1;
    @(posedge clock);
    hw_trigger <= 1'b0;
    @(posedge clock);
    chk("hw_start", 32'h1, {31'h0, scan_busy});
    // Entering stop without stop enable drops the running scan
    stop_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk("stop_abort", 32'h0, {31'h0, scan_busy});
    hw_trigger <= 1'b1;
    @(posedge clock);
    hw_trigger <= 1'b0;
    repeat (3) @(posedge clock);
    chk("stop_idle", 32'h0, {31'h0, scan_busy});
    wake_cnt = 0;
    scan(4'h3, 1'b1, 1'b0, 12'hFFF, 32'h1000_00F0);
    chk("wakeup", 32'h1, 32'(wake_cnt));
    stop_mode <= 1'b0;
    $display("test_stop_hw done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {wr, rd, hw_trigger, stop_mode} = 4'h0;
    addr = 32'h0;
    wdata = 32'h0;
    half_per = 4'h0;
    cur_ch = 4'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_regs();
    test_eos_irq();
    test_range();
    test_stop_hw();
    finish_test();
  end

  // Longest scan is about 8200 cycles; the rest is a few hundred
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    finish_test();
  end
endmodule
